// >>> sli_pkg.sv
package sli_pkg;

  // Clock rate and the base tick that times every lamp pattern
  localparam int CLK_KHZ          = 10000;
  localparam int TICK_MS          = 25;
  localparam int TICK_CYCLES_DFLT = TICK_MS * CLK_KHZ;

  // Pattern times in milliseconds
  localparam int TEST_MS      = 100;
  localparam int FAST_MS      = 75;
  localparam int HALF_MS      = 500;
  localparam int FLICK_ON_MS  = 1000;
  localparam int FLICK_OFF_MS = 300;
  localparam int STEADY_MS    = 500;
  localparam int BLIP_MS      = 50;

  // Pattern times in ticks
  localparam logic [5:0] TEST_TICKS      = 6'(TEST_MS / TICK_MS);
  localparam logic [5:0] FAST_TICKS      = 6'(FAST_MS / TICK_MS);
  localparam logic [5:0] HALF_TICKS      = 6'(HALF_MS / TICK_MS);
  localparam logic [5:0] FLICK_ON_TICKS  = 6'(FLICK_ON_MS / TICK_MS);
  localparam logic [5:0] FLICK_OFF_TICKS = 6'(FLICK_OFF_MS / TICK_MS);
  localparam logic [5:0] STEADY_TICKS    = 6'(STEADY_MS / TICK_MS);
  localparam logic [5:0] BLIP_TICKS      = 6'(BLIP_MS / TICK_MS);
  localparam logic [2:0] TEST_FLASHES    = 3'h3;

  // Configuration switches and the cutoff ladder
  localparam int         SW_NUM     = 10;
  localparam logic [2:0] CUT_OFF    = 3'h0;
  localparam logic [2:0] CUT_LEAD   = 3'h1;
  localparam logic [4:0] CUT_STEP_V = 5'h03;

  // Synchroniser lane positions
  localparam int SYNC_W    = 24;
  localparam int IDX_SW    = 0;
  localparam int IDX_OC    = 10;
  localparam int IDX_OH    = 11;
  localparam int IDX_MBL   = 12;
  localparam int IDX_MBH   = 13;
  localparam int IDX_LBL   = 14;
  localparam int IDX_QF    = 15;
  localparam int IDX_PULSE = 16;
  localparam int IDX_SER   = 17;
  localparam int IDX_MACT1 = 18;
  localparam int IDX_MACT2 = 19;
  localparam int IDX_ENC   = 20;

  // Register map, byte addresses
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_SWITCH = 12'h008;
  localparam logic [11:0] REG_ENC    = 12'h00C;

  // Field positions and reset values
  localparam int         CTRL_LAMP_TEST_BIT = 0;
  localparam logic       CTRL_LAMP_TEST_RST = 1'b0;
  localparam int         ST_MODE_LSB        = 0;
  localparam int         ST_CUT_LSB         = 4;
  localparam int         ST_FAULT_LSB       = 7;
  localparam int         ST_RUN_BIT         = 14;
  localparam int         ST_QF_BIT          = 15;
  localparam int         ST_INH_BIT         = 16;
  localparam int         ENC1_LSB           = 16;
  localparam logic [15:0] ENC_RST           = 16'h0000;

  typedef enum logic [3:0] {
    MODE_SERVO   = 4'b0001,
    MODE_ANALOG  = 4'b0010,
    MODE_SSERIAL = 4'b0100,
    MODE_PSERIAL = 4'b1000
  } sli_mode_t;

  typedef enum logic [6:0] {
    FLT_NONE = 7'b0000001,
    FLT_OC   = 7'b0000010,
    FLT_OH   = 7'b0000100,
    FLT_MBL  = 7'b0001000,
    FLT_MBH  = 7'b0010000,
    FLT_LBL  = 7'b0100000,
    FLT_QF   = 7'b1000000
  } sli_fault_t;

  typedef enum logic [1:0] {
    PH_TEST = 2'b01,
    PH_RUN  = 2'b10
  } sli_phase_t;

endpackage : sli_pkg

// >>> sli_sync_if.sv
interface sli_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;

  modport core (input raw, output sync);
  modport user (output raw, input sync);
endinterface : sli_sync_if

// >>> sli_sync.sv
module sli_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw pins in, settled copies out
  sli_sync_if.core port
);
  import sli_pkg::*;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;

  // Two flops per lane; only stage2 reads stage1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= port.raw;
      stage2 <= stage1;
    end
  end

  assign port.sync = stage2;

endmodule : sli_sync

// >>> sli_indicator.sv
// What this block does
// - After power-up flash all three lamps three times before normal display.
// - Analog mode keeps the activity lamp lit steadily.
// - Servo mode keeps activity lamp lit, blinking briefly on each pulse.
// - Serial modes keep activity lamp lit, blinking briefly on receive.
// - Motor lamp lit while either motor channel is active.
// - Over-current holds the fault lamp lit steadily.
// - Over-heat blinks the fault lamp at 0.075 second intervals.
// - Main battery low blinks the fault lamp at half-second intervals unless the cutoff is off.
// - Main battery high flickers fault lamp, 1 s lit, 0.3 s dark.
// - Logic battery low blinks fault lamp 0.5 s lit, 0.5 s dark.
// - Decoder failure at start-up alternates fault and motor lamps.
// - Switches 8 to 10 pick off, lead-acid, or 6V to 21V cutoff.
// - Inhibit motors when main battery falls below the selected cutoff.
// - Active-low reset pin reinitialises everything while held low.
// - Ten switches, on reads as one, off reads as zero.
// - Exactly four control modes are decoded from the switches.
// - Servo mode takes speed and direction from servo pulses; this block uses ctrl_pulse only to blink the activity lamp.
// - Encoders count up when A leads B, down when B leads.
// - Switches 1, 2 and 3 all off select analog mode.
// - Switch 1 on is servo; 1 off, 2 on, 3 off is simple serial.
//
// Decided for this implementation: register access over APB and the address map.
module sli_indicator #(
  parameter int TICK_CYCLES = sli_pkg::TICK_CYCLES_DFLT
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Configuration switch bank, bit n is switch n+1
  input  wire logic [9:0]         config_switch,
  // Fault sensing
  input  wire logic               over_current,
  input  wire logic               over_heat,
  input  wire logic               main_batt_low,
  input  wire logic               main_batt_high,
  input  wire logic               logic_batt_low,
  input  wire logic               quad_decoder_fail,
  // Activity sensing
  input  wire logic               ctrl_pulse,
  input  wire logic               serial_rx_active,
  input  wire logic               motor1_active,
  input  wire logic               motor2_active,
  // Encoder channels
  input  wire logic               enc1_a,
  input  wire logic               enc1_b,
  input  wire logic               enc2_a,
  input  wire logic               enc2_b,
  // Lamps
  output logic                    activity_lamp,
  output logic                    motor_active_lamp,
  output logic                    fault_lamp,
  // Decoded configuration
  output sli_pkg::sli_mode_t      op_mode,
  output logic      [2:0]         cutoff_code,
  output logic      [4:0]         cutoff_volts,
  output logic                    batt_inhibit
);
  import sli_pkg::*;

  sli_sync_if #(.W(SYNC_W)) pins ();

  logic [17:0] tick_cnt;
  logic        tick;
  sli_phase_t  phase;
  logic [5:0]  test_cnt;
  logic [2:0]  flash_cnt;
  logic        test_on;
  logic        test_end;
  logic        qf_latched;
  sli_fault_t  fault_sel;
  sli_fault_t  next_fault;
  logic [5:0]  fcnt;
  logic        fault_on;
  logic [5:0]  on_len;
  logic [5:0]  off_len;
  logic        steady_on;
  logic [5:0]  bcnt;
  logic        pulse_d;
  logic        ser_d;
  logic        act_edge;
  logic        lamp_test;
  logic [9:0]  sw_s;
  logic [31:0] rd_word;
  logic        addr_hit;
  logic        wr_take;

  // Every switch, sensing and encoder pin is brought into the clock domain first; the APB pins are used directly
  assign pins.raw = {enc2_b, enc2_a, enc1_b, enc1_a,
                     motor2_active, motor1_active, serial_rx_active,
                     ctrl_pulse, quad_decoder_fail, logic_batt_low,
                     main_batt_high, main_batt_low, over_heat,
                     over_current, config_switch};
  sli_sync #(.W(SYNC_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .port    (pins)
  );
  // Switch on reads as one
  assign sw_s = pins.sync[IDX_SW +: SW_NUM];

  // Prescaler for the pattern tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 18'h00000;
      tick     <= 1'b0;
    end else if (tick_cnt == 18'(TICK_CYCLES - 1)) begin
      tick_cnt <= 18'h00000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 18'h00001;
      tick     <= 1'b0;
    end
  end

  // Last dark period of the third flash
  assign test_end = tick && !test_on && (test_cnt == TEST_TICKS - 6'h01)
                    && (flash_cnt == TEST_FLASHES - 3'h1);

  // Power-up lamp flash, then normal display
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase     <= PH_TEST;
      test_cnt  <= 6'h00;
      flash_cnt <= 3'h0;
      test_on   <= 1'b1;
    end else begin
      case (phase)
        PH_TEST: begin
          if (tick) begin
            if (test_cnt == TEST_TICKS - 6'h01) begin
              test_cnt <= 6'h00;
              test_on  <= !test_on;
              if (!test_on) begin
                if (test_end) begin
                  phase <= PH_RUN;
                end else begin
                  flash_cnt <= flash_cnt + 3'h1;
                end
              end
            end else begin
              test_cnt <= test_cnt + 6'h01;
            end
          end
        end
        PH_RUN: test_on <= 1'b0;
        default: phase <= PH_TEST;
      endcase
    end
  end

  // Capture mode, cutoff and decoder health once after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_mode      <= MODE_ANALOG;
      cutoff_code  <= CUT_OFF;
      cutoff_volts <= 5'h00;
      qf_latched   <= 1'b0;
    end else if (test_end) begin
      // Settled switches are read only now
      if (sw_s[0]) begin
        op_mode <= MODE_SERVO;
      end else if (!sw_s[1] && !sw_s[2]) begin
        op_mode <= MODE_ANALOG;
      end else if (sw_s[1] && !sw_s[2]) begin
        op_mode <= MODE_SSERIAL;
      end else begin
        op_mode <= MODE_PSERIAL;
      end
      // Switch 8 is the low bit of the cutoff code
      cutoff_code <= {sw_s[9], sw_s[8], sw_s[7]};
      cutoff_volts <= ({sw_s[9], sw_s[8], sw_s[7]} > CUT_LEAD)
                      ? 5'({2'b00, sw_s[9], sw_s[8], sw_s[7]}) * CUT_STEP_V
                      : 5'h00;
      qf_latched <= pins.sync[IDX_QF];
    end
  end
  // Motor inhibit while below an enabled cutoff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      batt_inhibit <= 1'b0;
    end else begin
      batt_inhibit <= (phase == PH_RUN) && (cutoff_code != CUT_OFF)
                      && pins.sync[IDX_MBL];
    end
  end

  // Pick the most urgent fault to show
  always_comb begin
    next_fault = FLT_NONE;
    if (phase != PH_RUN) begin
      next_fault = FLT_NONE;
    end else if (pins.sync[IDX_OC]) begin
      next_fault = FLT_OC;
    end else if (pins.sync[IDX_OH]) begin
      next_fault = FLT_OH;
    end else if (pins.sync[IDX_MBL] && cutoff_code != CUT_OFF) begin
      next_fault = FLT_MBL;
    end else if (pins.sync[IDX_MBH]) begin
      next_fault = FLT_MBH;
    end else if (pins.sync[IDX_LBL]) begin
      next_fault = FLT_LBL;
    end else if (qf_latched) begin
      next_fault = FLT_QF;
    end
  end
  // Lit and dark lengths; logic battery and decoder failure share one
  always_comb begin
    steady_on = (fault_sel == FLT_OC);
    case (fault_sel)
      FLT_OH: begin
        on_len  = FAST_TICKS;
        off_len = FAST_TICKS;
      end
      FLT_MBL: begin
        on_len  = HALF_TICKS;
        off_len = HALF_TICKS;
      end
      FLT_MBH: begin
        on_len  = FLICK_ON_TICKS;
        off_len = FLICK_OFF_TICKS;
      end
      default: begin
        on_len  = STEADY_TICKS;
        off_len = STEADY_TICKS;
      end
    endcase
  end

  // Fault pattern phase, restarted whenever the shown fault changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_sel <= FLT_NONE;
      fcnt      <= 6'h00;
      fault_on  <= 1'b0;
    end else if (next_fault != fault_sel) begin
      fault_sel <= next_fault;
      fcnt      <= 6'h00;
      fault_on  <= (next_fault != FLT_NONE);
    end else if (fault_sel == FLT_NONE) begin
      fault_on <= 1'b0;
    end else if (steady_on) begin
      fault_on <= 1'b1;
    end else if (tick) begin
      if (fcnt >= (fault_on ? on_len : off_len) - 6'h01) begin
        fcnt     <= 6'h00;
        fault_on <= !fault_on;
      end else begin
        fcnt <= fcnt + 6'h01;
      end
    end
  end
  // Activity edge of the source that the mode listens to
  assign act_edge = (op_mode == MODE_SERVO)
                    ? (pins.sync[IDX_PULSE] && !pulse_d)
                    : (pins.sync[IDX_SER] && !ser_d);

  // Brief dark blip on control activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_d <= 1'b0;
      ser_d   <= 1'b0;
      bcnt    <= 6'h00;
    end else begin
      pulse_d <= pins.sync[IDX_PULSE];
      ser_d   <= pins.sync[IDX_SER];
      if (phase == PH_RUN && op_mode != MODE_ANALOG && act_edge) begin
        bcnt <= BLIP_TICKS;
      end else if (tick && bcnt != 6'h00) begin
        bcnt <= bcnt - 6'h01;
      end
    end
  end
  // Lamp drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      activity_lamp     <= 1'b0;
      motor_active_lamp <= 1'b0;
      fault_lamp        <= 1'b0;
    end else if (phase != PH_RUN || lamp_test) begin
      activity_lamp     <= test_on || lamp_test;
      motor_active_lamp <= test_on || lamp_test;
      fault_lamp        <= test_on || lamp_test;
    end else begin
      activity_lamp <= (op_mode == MODE_ANALOG) || (bcnt == 6'h00);
      motor_active_lamp <= (fault_sel == FLT_QF) ? !fault_on
                           : (pins.sync[IDX_MACT1]
                              || pins.sync[IDX_MACT2]);
      fault_lamp <= fault_on;
    end
  end
  // Quadrature counters, one per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_enc
    logic        a_now;
    logic        b_now;
    logic [1:0]  prev;
    logic [15:0] count;
    assign a_now = pins.sync[IDX_ENC + 2 * ch];
    assign b_now = pins.sync[IDX_ENC + 2 * ch + 1];
    // A single-bit change steps; A leading counts up
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        prev  <= 2'h0;
        count <= ENC_RST;
      end else begin
        prev <= {a_now, b_now};
        if ((a_now ^ prev[1]) != (b_now ^ prev[0])) begin
          count <= (a_now ^ prev[0]) ? count + 16'h0001
                                     : count - 16'h0001;
        end
      end
    end
  end
  // Read decode
  always_comb begin
    rd_word  = 32'h00000000;
    addr_hit = 1'b1;
    case (paddr)
      REG_CTRL: rd_word[CTRL_LAMP_TEST_BIT] = lamp_test;
      REG_STATUS: begin
        rd_word[ST_MODE_LSB +: 4]  = op_mode;
        rd_word[ST_CUT_LSB +: 3]   = cutoff_code;
        rd_word[ST_FAULT_LSB +: 7] = fault_sel;
        rd_word[ST_RUN_BIT]        = (phase == PH_RUN);
        rd_word[ST_QF_BIT]         = qf_latched;
        rd_word[ST_INH_BIT]        = batt_inhibit;
      end
      REG_SWITCH: rd_word[SW_NUM-1:0] = sw_s;
      REG_ENC: rd_word = {g_enc[1].count, g_enc[0].count};
      default: addr_hit = 1'b0;
    endcase
  end
  // APB answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !addr_hit;
      prdata  <= pwrite ? 32'h00000000 : rd_word;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
  // Writes land at the completing edge
  assign wr_take = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_test <= CTRL_LAMP_TEST_RST;
    end else if (wr_take && paddr == REG_CTRL) begin
      lamp_test <= pwdata[CTRL_LAMP_TEST_BIT];
    end
  end

endmodule : sli_indicator

// >>> sli_env_model.sv
module sli_env_model (
  // Requests from the bench
  input  wire logic       hold_reset,
  input  wire logic [9:0] switch_set,
  // Pins seen by the block
  output logic            presetn,
  output logic      [9:0] config_switch
);
  // Reset pin pulled to ground while a hard reset is requested
  assign presetn = !hold_reset;
  // Switch bank: on reads as one, off as zero
  assign config_switch = switch_set;
endmodule : sli_env_model

// >>> sli_indicator_assertions.sv
module sli_indicator_assertions #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Sensing
  input wire logic               over_current,
  input wire logic               main_batt_low,
  input wire logic               quad_decoder_fail,
  input wire logic               serial_rx_active,
  input wire logic               motor1_active,
  input wire logic               motor2_active,
  // Lamps and configuration
  input wire logic               activity_lamp,
  input wire logic               motor_active_lamp,
  input wire logic               fault_lamp,
  input wire sli_pkg::sli_mode_t op_mode,
  input wire logic [2:0]         cutoff_code,
  input wire logic [4:0]         cutoff_volts,
  input wire logic               batt_inhibit
);
  import sli_pkg::*;
  localparam int TEST_LEN = 24 * TICK_CYCLES + 8;
  logic [15:0] run_cnt;
  logic        running;
  logic        lamp_test_on;

  // Cycles since release, saturating past the power-up test
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt <= 16'h0000;
    end else if (!running) begin
      run_cnt <= run_cnt + 16'h0001;
    end
  end
  assign running = (run_cnt >= 16'(TEST_LEN));

  // Shadow of the lamp test bit, since it overrides every lamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_test_on <= 1'b0;
    end else if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
      lamp_test_on <= pwdata[CTRL_LAMP_TEST_BIT];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence access_wait;
    psel && penable && !pready;
  endsequence
  sequence dark_reset;
    !activity_lamp && !motor_active_lamp && !fault_lamp &&
      op_mode == MODE_ANALOG;
  endsequence
  sequence all_lit;
    activity_lamp && motor_active_lamp && fault_lamp;
  endsequence

  chk_apb_wait:
    assert property (access_wait |=> pready)
    else $error("No answer one cycle after the access phase");
  chk_pready_pulse:
    assert property (pready |=> !pready)
    else $error("pready held for more than one cycle");
  chk_err_decode:
    assert property (pready |->
      pslverr == ((paddr > 12'h00C) || (paddr[1:0] != 2'h0)))
    else $error("pslverr does not match address decode");
  chk_power_flash:
    assert property ($rose(presetn) |-> dark_reset ##[1:3] all_lit)
    else $error("Lamps not dark in reset or not lit after release");
  chk_analog_steady:
    assert property (running && op_mode == MODE_ANALOG |-> activity_lamp)
    else $error("Activity lamp dark in analog mode");
  chk_motor_lamp:
    assert property ((running && !lamp_test_on && !quad_decoder_fail &&
      $stable({motor1_active, motor2_active}))[*8] |->
      motor_active_lamp == (motor1_active || motor2_active))
    else $error("Motor lamp does not follow motor activity");
  chk_oc_steady:
    assert property ((running && over_current)[*8] |-> fault_lamp)
    else $error("Fault lamp not steady under over-current");
  chk_batt_inhibit:
    assert property ((running && cutoff_code != 3'h0 &&
      $stable(main_batt_low))[*6] |-> batt_inhibit == main_batt_low)
    else $error("Battery inhibit does not follow low main battery");
  chk_cutoff_volts:
    assert property (running |-> cutoff_volts == ((cutoff_code >= 3'h2) ?
      {2'b00, cutoff_code} * CUT_STEP_V : 5'h00))
    else $error("Cutoff voltage does not match cutoff code");
  chk_rx_blink:
    assert property (running && !lamp_test_on && $rose(serial_rx_active) &&
      (op_mode == MODE_SSERIAL || op_mode == MODE_PSERIAL) |->
      ##[2:12] !activity_lamp)
    else $error("Activity lamp did not blink on serial receive");
endmodule : sli_indicator_assertions

bind sli_indicator sli_indicator_assertions #(
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .over_current, .main_batt_low, .quad_decoder_fail,
  .serial_rx_active, .motor1_active, .motor2_active, .activity_lamp,
  .motor_active_lamp, .fault_lamp, .op_mode, .cutoff_code, .cutoff_volts,
  .batt_inhibit
);

// >>> tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sli_pkg::*;
  localparam int TICK = 4;
  logic        pclk, presetn, hold_reset, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic [9:0]  switch_set, config_switch;
  logic        over_current, over_heat, main_batt_low, main_batt_high;
  logic        logic_batt_low, quad_decoder_fail, ctrl_pulse;
  logic        serial_rx_active, motor1_active, motor2_active;
  logic        enc1_a, enc1_b, enc2_a, enc2_b;
  logic        activity_lamp, motor_active_lamp, fault_lamp, batt_inhibit;
  sli_mode_t   op_mode;
  logic [2:0]  cutoff_code;
  logic [4:0]  cutoff_volts;
  int          miscompares = 0;
  int          checks_done = 0;
  // Fault table: {oc, oh, main low, main high, logic low}, times in ticks
  logic [4:0]  flt_tab [7] = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h0C, 5'h07,
                               5'h18};
  int          on_tab [7] = '{3, 20, 40, 20, 3, 20, 0};
  int          off_tab [7] = '{3, 20, 12, 20, 3, 20, 0};

  sli_env_model env (.hold_reset, .switch_set, .presetn, .config_switch);
  sli_indicator #(.TICK_CYCLES(TICK)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .config_switch, .over_current, .over_heat,
    .main_batt_low, .main_batt_high, .logic_batt_low, .quad_decoder_fail,
    .ctrl_pulse, .serial_rx_active, .motor1_active, .motor2_active,
    .enc1_a, .enc1_b, .enc2_a, .enc2_b, .activity_lamp,
    .motor_active_lamp, .fault_lamp, .op_mode, .cutoff_code,
    .cutoff_volts, .batt_inhibit);

  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask : step

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        miscompares++;
        report_and_stop();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic restart(input logic [9:0] sw);
    @(posedge pclk);
    hold_reset <= 1'b1;
    switch_set <= sw;
    step(3);
    hold_reset <= 1'b0;
  endtask : restart

  // Cycles the fault lamp stays at one level, bounded
  task automatic lamp_run(input logic v, output int n);
    n = 0;
    while (fault_lamp === v) begin
      @(posedge pclk);
      n++;
      if (n > 400) begin
        miscompares++;
        report_and_stop();
      end
    end
  endtask : lamp_run

  // Raise one activity pin and watch for a dip of the activity lamp
  task automatic blip(input int pin, output logic seen);
    @(posedge pclk);
    if (pin == 0) ctrl_pulse <= 1'b1;
    else serial_rx_active <= 1'b1;
    seen = 1'b0;
    repeat (16) begin
      @(posedge pclk);
      if (activity_lamp === 1'b0) seen = 1'b1;
    end
    ctrl_pulse <= 1'b0;
    serial_rx_active <= 1'b0;
    step(24);
  endtask : blip

  task automatic sc_config();
    int        rises;
    logic      seen, prev;
    logic [2:0] c;
    sli_mode_t m;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      m = c[0] ? MODE_SERVO : (c == 3'h0) ? MODE_ANALOG :
          (c == 3'h2) ? MODE_SSERIAL : MODE_PSERIAL;
      restart({c, 4'h0, c});
      rises = 0;
      prev = 1'b0;
      repeat (140) begin
        @(posedge pclk);
        if (fault_lamp === 1'b1 && prev === 1'b0) rises++;
        prev = fault_lamp;
      end
      chk(32'(rises), 32'd3);
      chk(32'(op_mode), 32'(m));
      chk(32'(cutoff_code), 32'(c));
      chk(32'(cutoff_volts), (c >= 3'h2) ? 32'(c) * 32'd3 : 32'd0);
      blip(0, seen);
      chk(32'(seen), 32'(m == MODE_SERVO));
      blip(1, seen);
      chk(32'(seen), 32'(m == MODE_SSERIAL || m == MODE_PSERIAL));
      motor1_active <= c[0];
      motor2_active <= ~c[0];
      step(8);
      chk(32'(motor_active_lamp), 32'h1);
      motor1_active <= 1'b0;
      motor2_active <= 1'b0;
      step(8);
      chk(32'(motor_active_lamp), 32'h0);
    end
  endtask : sc_config

  task automatic sc_faults();
    int n, on_c, off_c;
    for (int k = 0; k < 7; k++) begin
      @(posedge pclk);
      {over_current, over_heat, main_batt_low, main_batt_high,
       logic_batt_low} <= flt_tab[k];
      step(10);
      chk(32'(batt_inhibit), 32'(flt_tab[k][2]));
      if (on_tab[k] == 0) begin
        n = 0;
        repeat (200) begin
          @(posedge pclk);
          if (fault_lamp !== 1'b1) n++;
        end
        chk(32'(n), 32'd0);
      end else begin
        lamp_run(1'b1, n);
        lamp_run(1'b0, n);
        lamp_run(1'b1, on_c);
        lamp_run(1'b0, off_c);
        chk(32'(on_c), 32'(on_tab[k] * TICK));
        chk(32'(off_c), 32'(off_tab[k] * TICK));
      end
    end
    {over_current, over_heat, main_batt_low, main_batt_high,
     logic_batt_low} <= 5'h00;
    step(20);
  endtask : sc_faults

  task automatic sc_encoder();
    logic [1:0] fwd [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
    logic [1:0] bwd [2] = '{2'b01, 2'b11};
    for (int j = 0; j < 4; j++) begin
      @(posedge pclk);
      {enc1_a, enc1_b} <= fwd[j];
      if (j < 2) {enc2_a, enc2_b} <= bwd[j];
      step(6);
    end
    apb(1'b0, REG_ENC, 32'h0);
    chk(rd, 32'hFFFE0004);
  endtask : sc_encoder

  task automatic sc_apb();
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    step(6);
    chk({29'h0, activity_lamp, motor_active_lamp, fault_lamp}, 32'h7);
    apb(1'b1, REG_STATUS, 32'hFFFFFFFF);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h000040F1);
    apb(1'b0, REG_SWITCH, 32'h0);
    chk(rd, 32'h00000387);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h006, 32'h1);
    chk(32'(err), 32'h1);
    restart({3'h7, 4'h0, 3'h7});
    step(2);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 32'h0);
  endtask : sc_apb

  task automatic sc_quad();
    int   n, tog;
    logic prev;
    quad_decoder_fail <= 1'b1;
    restart({3'h7, 4'h0, 3'h7});
    step(140);
    n = 0;
    tog = 0;
    prev = fault_lamp;
    repeat (200) begin
      @(posedge pclk);
      if (fault_lamp === motor_active_lamp) n++;
      if (fault_lamp !== prev) tog++;
      prev = fault_lamp;
    end
    chk(32'(n), 32'd0);
    chk(32'(tog >= 2), 32'd1);
  endtask : sc_quad

  // Main sequence
  initial begin
    hold_reset = 1'b1;
    switch_set = 10'h000;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {over_current, over_heat, main_batt_low, main_batt_high, logic_batt_low,
     quad_decoder_fail, ctrl_pulse, serial_rx_active, motor1_active,
     motor2_active, enc1_a, enc1_b, enc2_a, enc2_b} = '0;
    step(3);
    hold_reset <= 1'b0;
    sc_config();
    sc_faults();
    sc_encoder();
    sc_apb();
    sc_quad();
    report_and_stop();
  end
endmodule : tb_top
